// >>> verilog/ssep_port.v
// ssep_port.v: synchronous serial expansion port, master or slave,
// with an APB register slave for control, flags and data byte.
// assumes one 25 MHz clock; pins and link clock are asynchronous and
// pass two flip-flops; the pad logic resolves pin, output and enable.
`timescale 1ns/1ps
`include "ssep_consts.vh"

// Summary of operation
// - master rate is clock divided 4/8/16/64
// - slave ignores rate, master clock max fc/4
// - master emits exactly eight clock pulses
// - order bit: 0 bit7 first, 1 bit0
// - control bit 3: clock idle low/high
// - control bit 2 selects clock phase
// - disable waits for running transfer end
// - master data write starts byte exchange
// - write while busy dropped, collision flag
// - collision cleared by flags then data
// - overflow reads zero in master mode
// - slave byte while done set: overflow
// - overflow cleared by access pair, master
// - shift out and in simultaneously
// - slave deselected ignores clock, no capture
// - change on one edge, sample opposite
// - master drives out-line, slave in-line reversed
// - clock pin output master, input slave
// - slave data out enabled with port
// - phase 0: first bit half period early
// - phase 1: data changes at first edge
// - done set after last shift, interrupt
// - shift register holds received byte after
module ssep_port (
  // clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  // apb slave
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // serial clock pin
  input  wire        sclk_i,
  output wire        sclk_o,
  output wire        sclk_oe,
  // master-out data pin
  input  wire        mosi_i,
  output wire        mosi_o,
  output wire        mosi_oe,
  // master-in data pin
  input  wire        miso_i,
  output wire        miso_o,
  output wire        miso_oe,
  // slave select, active low
  input  wire        ss_n_i,
  // transfer done event
  output wire        xfer_irq
);

  // control and flags
  reg  [7:0] ctrl_q;
  reg        done_q;
  reg        done_prev_q;
  reg        write_collision_flag_q;
  reg        ovf_q;
  reg        arm_q;
  reg        port_on_q;
  // shift engine
  reg  [7:0] sr_q;
  reg        out_q;
  reg        run_q;
  reg  [3:0] edge_cnt_q;
  reg  [5:0] div_q;
  reg        sclk_q;
  reg  [3:0] sbit_q;
  reg        sclk_prev_q;
  // late capture of the master input line, and the end-of-byte tail
  reg        smp1_q;
  reg        smp2_q;
  reg        fin1_q;
  reg        fin2_q;
  reg [31:0] prdata_q;

  wire [3:0] pins_s;
  wire       sclk_s;
  wire       mosi_s;
  wire       miso_s;
  wire       ss_n_s;

  // pins cross into the clock domain before any logic sees them
  ssep_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (ref_clk),
    .rst      (sys_rst),
    .async_in ({ss_n_i, miso_i, mosi_i, sclk_i}),
    .sync_out (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[2];
  assign ss_n_s = pins_s[3];

  // control fields
  // phase from bit 2
  wire       phase     = ctrl_q[`SSEP_CTL_PHASE];
  wire       idle_lvl  = ctrl_q[`SSEP_CTL_IDLE];
  wire       is_master = ctrl_q[`SSEP_CTL_ROLE];
  wire       lsb_first = ctrl_q[`SSEP_CTL_ORDER];
  wire [1:0] rate      = ctrl_q[`SSEP_CTL_RATE_HI:`SSEP_CTL_RATE_LO];

  function [5:0] half_of;
    input [1:0] code;
    begin
      case (code)
        2'b00:   half_of = `SSEP_HALF_DIV4;
        2'b01:   half_of = `SSEP_HALF_DIV8;
        2'b10:   half_of = `SSEP_HALF_DIV16;
        default: half_of = `SSEP_HALF_DIV64;
      endcase
    end
  endfunction

  function out_bit;
    input [7:0] v;
    input       lsb;
    begin
      out_bit = lsb ? v[0] : v[7];
    end
  endfunction

  function [7:0] shift_in;
    input [7:0] v;
    input       lsb;
    input       b;
    begin
      shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
    end
  endfunction

  // apb decode; zero wait states, unmapped word gives an error
  wire [9:0] widx    = paddr[11:2];
  wire       hit_ctl = (widx == `SSEP_IDX_CTRL);
  wire       hit_flg = (widx == `SSEP_IDX_FLAGS);
  wire       hit_byt = (widx == `SSEP_IDX_BYTE);
  wire       mapped  = (paddr[1:0] == 2'b00) & (hit_ctl | hit_flg | hit_byt);
  wire       access  = psel & penable;
  wire       wr_ctl  = access & pwrite & mapped & hit_ctl;
  wire       rd_flg  = access & ~pwrite & mapped & hit_flg;
  wire       acc_byt = access & mapped & hit_byt;
  wire       wr_byt  = acc_byt & pwrite;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  wire [7:0] flags_rd = {done_q, write_collision_flag_q, ovf_q & ~is_master, 5'h00};

  // slave framing
  // slave ignores rate
  wire slave_act = port_on_q & ~is_master & ~ss_n_s;
  wire s_edge    = sclk_s ^ sclk_prev_q;
  wire s_lead    = s_edge & (sclk_s != idle_lvl);
  // sample on leading edge for phase 0, trailing for phase 1
  wire s_sample  = s_edge & (s_lead ^ phase);

  // master timing
  wire m_tick    = run_q & (div_q == half_of(rate) - 6'h01);
  // even edge index is a leading edge
  wire m_sample  = ~edge_cnt_q[0] ^ phase;

  // master input bit, taken two cycles after its sample edge
  // the synchroniser delays miso by two clocks, so at the fastest rate
  // a capture at the sample tick itself would still see the previous bit
  wire [7:0] sr_shift  = smp2_q ? shift_in(sr_q, lsb_first, miso_s) : sr_q;

  // transfer in progress, also a selected phase-0 slave
  // the late-capture tail counts as busy so no write lands mid-shift
  wire xfer_busy = run_q | fin1_q | fin2_q | (sbit_q != 4'h0) |
                   (port_on_q & ~is_master & ~phase & ~ss_n_s);

  // read data registered in the setup cycle
  always @* begin
    prdata = prdata_q;
  end

  // capture read data before the access phase
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      if (hit_ctl & mapped)
        prdata_q <= {24'h000000, ctrl_q};
      else if (hit_flg & mapped)
        prdata_q <= {24'h000000, flags_rd};
      else if (hit_byt & mapped)
        prdata_q <= {24'h000000, sr_q};
      else
        prdata_q <= 32'h00000000;
    end
  end

  // control register, flags and the access-pair clear
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_q      <= `SSEP_CTRL_RST;
      port_on_q   <= 1'b0;
      done_prev_q <= 1'b0;
      arm_q       <= 1'b0;
    end else begin
      done_prev_q <= done_q;
      if (wr_ctl)
        ctrl_q <= pwdata[7:0];
      if (!xfer_busy)
        port_on_q <= ctrl_q[`SSEP_CTL_ENABLE];
      // flags read arms, data access fires
      if (rd_flg)
        arm_q <= 1'b1;
      else if (acc_byt)
        arm_q <= 1'b0;
    end
  end

  // shift register, master and slave engines; sets come after clears
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      done_q      <= 1'b0;
      write_collision_flag_q      <= 1'b0;
      ovf_q       <= 1'b0;
      sr_q        <= `SSEP_BYTE_RST;
      out_q       <= 1'b0;
      run_q       <= 1'b0;
      edge_cnt_q  <= 4'h0;
      div_q       <= 6'h00;
      sclk_q      <= 1'b0;
      sbit_q      <= 4'h0;
      sclk_prev_q <= 1'b0;
      smp1_q      <= 1'b0;
      smp2_q      <= 1'b0;
      fin1_q      <= 1'b0;
      fin2_q      <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      // late-capture pipeline: sample edges and the last edge, two deep
      smp1_q      <= m_tick & m_sample;
      smp2_q      <= smp1_q;
      fin1_q      <= m_tick & (edge_cnt_q == `SSEP_LAST_EDGE);
      fin2_q      <= fin1_q;
      if (acc_byt & arm_q) begin
        done_q <= 1'b0;
        write_collision_flag_q <= 1'b0;
        ovf_q  <= 1'b0;
      end
      if (is_master)
        ovf_q <= 1'b0;
      if (!run_q)
        sclk_q <= idle_lvl;
      if (wr_byt & xfer_busy) begin
        write_collision_flag_q <= 1'b1;
      end else if (wr_byt) begin
        sr_q <= pwdata[7:0];
        if (is_master & port_on_q) begin
          run_q      <= 1'b1;
          edge_cnt_q <= 4'h0;
          div_q      <= 6'h00;
          // phase 0 shows first bit now
          if (!phase)
            out_q <= out_bit(pwdata[7:0], lsb_first);
        end
      end
      if (run_q) begin
        if (m_tick) begin
          div_q      <= 6'h00;
          edge_cnt_q <= edge_cnt_q + 4'h1;
          sclk_q     <= ~sclk_q;
          if (!m_sample)
            out_q <= out_bit(sr_shift, lsb_first);
          if (edge_cnt_q == `SSEP_LAST_EDGE)
            run_q <= 1'b0;
        end else begin
          div_q <= div_q + 6'h01;
        end
      end
      if (smp2_q)
        sr_q <= sr_shift;
      if (fin2_q)
        done_q <= 1'b1;
      if (!slave_act) begin
        sbit_q <= 4'h0;
      end else if (s_sample) begin
        sr_q   <= shift_in(sr_q, lsb_first, mosi_s);
        sbit_q <= sbit_q + 4'h1;
        if (sbit_q == `SSEP_LAST_BIT) begin
          sbit_q <= 4'h0;
          done_q <= 1'b1;
          if (done_q & ~(acc_byt & arm_q))
            ovf_q <= 1'b1;
        end
      end else if (s_edge) begin
        out_q <= out_bit(sr_q, lsb_first);
      end else if (~phase & (sbit_q == 4'h0) & ~wr_byt) begin
        // phase 0 slave presents first bit early
        out_q <= out_bit(sr_q, lsb_first);
      end
    end
  end

  assign sclk_oe = port_on_q & is_master;
  assign sclk_o  = sclk_q;

  assign mosi_oe = port_on_q & is_master;
  assign mosi_o  = out_q;

  assign miso_oe = port_on_q & ~is_master;
  assign miso_o  = out_q;

  assign xfer_irq = done_q & ~done_prev_q;

endmodule // ssep_port

// >>> verilog/ssep_consts.vh
// ssep_consts.vh: register map, field positions and reset values
// of the synchronous serial expansion port.
// assumes a 32-bit APB slave; indices are word indices (byte = 4 x index).
`ifndef SSEP_CONSTS_VH
`define SSEP_CONSTS_VH

// register word indices
`define SSEP_IDX_CTRL   10'h02a
`define SSEP_IDX_FLAGS  10'h02b
`define SSEP_IDX_BYTE   10'h02c

// control register fields
`define SSEP_CTL_RATE_LO 0
`define SSEP_CTL_RATE_HI 1
`define SSEP_CTL_PHASE   2
`define SSEP_CTL_IDLE    3
`define SSEP_CTL_ROLE    4
`define SSEP_CTL_ORDER   5
`define SSEP_CTL_ENABLE  6
`define SSEP_CTL_NOFAULT 7

// flags register fields
`define SSEP_FLG_FAULT 4
`define SSEP_FLG_OVF   5
`define SSEP_FLG_WRITE_COLLISION_FLAG  6
`define SSEP_FLG_DONE  7

// reset values
`define SSEP_CTRL_RST 8'h00
`define SSEP_BYTE_RST 8'h00

// half periods of the shift clock in system clocks (ratio / 2)
`define SSEP_HALF_DIV4  6'h02
`define SSEP_HALF_DIV8  6'h04
`define SSEP_HALF_DIV16 6'h08
`define SSEP_HALF_DIV64 6'h20

// shift clock edges in one byte, last edge index
`define SSEP_LAST_EDGE 4'hf
`define SSEP_LAST_BIT  4'h7

`endif

// >>> verilog/ssep_sync.v
// ssep_sync.v: two flip-flop synchroniser for a group of pin inputs.
// assumes the inputs are asynchronous to clk; output is clk-domain.
`timescale 1ns/1ps

module ssep_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // asynchronous inputs and their synchronised copies
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // ssep_sync

// >>> testbench/ssep_port_assertions.sv
// ssep_port_assertions.sv: pin and shift clock checks for ssep_port.
// assumes control writes at byte 0xa8 and one ref_clk domain.
`timescale 1ns/1ps
module ssep_chk (
  // clock, reset, apb
  input wire        ref_clk,
  input wire        sys_rst,
  input wire [11:0] paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  // pins
  input wire        sclk_o,
  input wire        sclk_oe,
  input wire        mosi_o,
  input wire        mosi_oe,
  input wire        miso_oe,
  input wire        xfer_irq
);
  logic [7:0] ctl_q;
  logic [4:0] tog_q;
  logic [5:0] gap_q;
  logic       sclk_q;
  wire        tgl  = sclk_o != sclk_q;
  wire  [5:0] half = ctl_q[1:0] == 2'h3 ? 6'h20 : 6'h02 << ctl_q[1:0];
  // shadow control byte; toggles per byte and gap since the last one
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ctl_q  <= 8'h00;
      tog_q  <= 5'h00;
      gap_q  <= 6'h00;
      sclk_q <= 1'b0;
    end else begin
      if (psel && penable && pwrite && paddr == 12'h0a8) ctl_q <= pwdata[7:0];
      tog_q  <= xfer_irq ? 5'h00 : tog_q + {4'h0, tgl && sclk_oe};
      gap_q  <= tgl ? 6'h00 : gap_q + 6'h01;
      sclk_q <= sclk_o;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=> !sclk_oe && !miso_oe && !xfer_irq)
    else $error("pins active after reset");
  AST_ROLE_PINS: assert property (sclk_oe |-> mosi_oe && !miso_oe)
    else $error("pin directions disagree");
  AST_MISO_EN: assert property ($rose(miso_oe) |-> ctl_q[6] && !ctl_q[4])
    else $error("slave data out without enable");
  AST_IDLE_LVL: assert property ($rose(sclk_oe) |-> sclk_o == ctl_q[3])
    else $error("shift clock not at idle level");
  AST_IRQ_ONE: assert property (xfer_irq |=> !xfer_irq)
    else $error("done event longer than one cycle");
  AST_EIGHT: assert property (xfer_irq && sclk_oe |-> tog_q == 5'h10)
    else $error("byte without sixteen clock edges");
  AST_NO_EXTRA: assert property (tog_q == 5'h10 |-> !tgl)
    else $error("clock edge after the byte");
  AST_RATE: assert property (sclk_oe && tgl && tog_q != 5'h00 |-> gap_q + 6'h01 == half)
    else $error("shift clock half period wrong");
  AST_HOLD: assert property (sclk_oe && tgl && sclk_o == (ctl_q[2] == ctl_q[3]) |-> $stable(mosi_o))
    else $error("data moved on a sample edge");
  cover property (xfer_irq && sclk_oe);
  cover property ($rose(miso_oe));
  cover property (tgl && tog_q == 5'h0f);
endmodule // ssep_chk

bind ssep_port ssep_chk ssep_chk_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_o(mosi_o),
  .mosi_oe(mosi_oe), .miso_oe(miso_oe), .xfer_irq(xfer_irq));

// >>> testbench/ssep_peer.sv
// ssep_peer.sv: behavioural slave peer facing the port in master mode.
// assumes it is selected while the port drives the shift clock.
`timescale 1ns/1ps
module ssep_peer (
  // pins
  input  wire        sclk,
  input  wire        mosi,
  input  wire        sel,
  // format and byte to return
  input  wire        phase,
  input  wire        idle,
  input  wire  [7:0] tx,
  output logic       miso,
  output logic [7:0] rx
);
  int k;
  initial miso = 1'b0;
  // phase 0 shows the first bit before any edge
  always @(posedge sel) begin
    k = phase ? -1 : 0;
    miso = phase ? ~miso : tx[7];
  end
  // sample on one edge, shift on the other
  always @(sclk) if (sel) begin
    if (sclk == (phase == idle)) rx = {rx[6:0], mosi};
    else begin
      k++;
      miso = k < 8 ? tx[7 - k] : ~miso;
    end
  end
  // a released line is not held, so show the inverse
  always @(negedge sel) miso = ~miso;
endmodule // ssep_peer

// >>> testbench/tb_top.sv
// tb_top.sv: self-checking bench for the serial port, master and slave.
// assumes zero or more apb wait states and a behavioural slave peer.
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] paddr   = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic        s_sclk = 1'b0, s_mosi = 1'b0, ss_n_i = 1'b1, er, sclk_p = 1'b0;
  logic [7:0]  cfg = 8'h00, ptx = 8'h00;
  logic [31:0] rd;
  wire  [31:0] prdata;
  wire  [7:0]  prx;
  wire         pready, pslverr, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, xfer_irq, pmiso;
  wire         sclk_i = sclk_oe ? sclk_o : s_sclk;
  wire         mosi_i = mosi_oe ? mosi_o : s_mosi;
  wire         miso_i = miso_oe ? miso_o : pmiso;
  int          failures = 0, comparisons = 0, cyc = 0, tog = 0, first = 0, last = 0;
  ssep_port ssep_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_i(sclk_i),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i),
    .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n_i), .xfer_irq(xfer_irq));
  ssep_peer ssep_peer_inst (.sclk(sclk_i), .mosi(mosi_i), .sel(sclk_oe), .phase(cfg[2]), .idle(cfg[3]),
    .tx(ptx), .miso(pmiso), .rx(prx));
  // 25 MHz system clock
  always #20 ref_clk = ~ref_clk;
  // census of driven shift clock edges, for count and spacing
  always @(posedge ref_clk) begin
    cyc++;
    if (sclk_o !== sclk_p && sclk_oe) begin
      if (tog == 0) first = cyc;
      last = cyc;
      tog++;
    end
    sclk_p = sclk_o;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 64) begin failures++; print_verdict; end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq;
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge ref_clk);
      if (xfer_irq === 1'b1) break;
    end
    if (n == 2000) begin failures++; print_verdict; end
  endtask
  // far master in mode 0 at 320 ns, well under a quarter of fc
  task automatic sbyte(input logic sn, input logic [7:0] b, output logic [7:0] got);
    @(posedge ref_clk);
    ss_n_i <= sn;
    for (int j = 7; j >= 0; j--) begin
      s_mosi <= b[j];
      repeat (4) @(posedge ref_clk);
      s_sclk <= 1'b1;
      got = {got[6:0], miso_i};
      repeat (4) @(posedge ref_clk);
      s_sclk <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    ss_n_i <= 1'b1;
  endtask
  function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
    ord = v;
    if (lsb) for (int j = 0; j < 8; j++) ord[j] = v[7 - j];
  endfunction
  initial begin
    logic [7:0] tb, b1, got;
    void'($urandom(89667));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 3; a++) begin
      apb(1'b0, 12'h0a8 + 12'(a * 4), 8'h00);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h0b4, 8'h00);
    chk({31'h0, er}, 32'h1);
    // every rate, each with its own one of the four clock formats, random order and bytes
    for (int i = 0; i < 4; i++) begin
      cfg = {2'b10, 1'($urandom), 1'b1, i[1], i[0], i[1:0]};
      // far clock rests at the idle level so the shared pin never jumps
      s_sclk <= cfg[3];
      ptx = 8'($urandom);
      tb = 8'($urandom);
      apb(1'b1, 12'h0a8, cfg);
      apb(1'b1, 12'h0a8, cfg | 8'h40);
      apb(1'b0, 12'h0a8, 8'h00);
      chk(rd, {24'h0, cfg | 8'h40});
      tog = 0;
      apb(1'b1, 12'h0b0, tb);
      apb(1'b1, 12'h0b0, ~tb);
      apb(1'b1, 12'h0a8, cfg);
      wait_irq;
      repeat (2) @(posedge ref_clk);
      chk(tog, 16);
      chk(last - first, 15 * (i == 3 ? 32 : 2 << i));
      chk(prx, ord(tb, cfg[5]));
      apb(1'b0, 12'h0ac, 8'h00);
      chk(rd, 32'h0c0);
      apb(1'b0, 12'h0b0, 8'h00);
      chk(rd, ord(ptx, cfg[5]));
      apb(1'b0, 12'h0ac, 8'h00);
      chk(rd, 32'h0);
    end
    // slave: role first, then enable; preload a reply byte
    s_sclk <= 1'b0;
    apb(1'b1, 12'h0a8, 8'h80);
    apb(1'b1, 12'h0a8, 8'hc0);
    b1 = 8'($urandom);
    tb = 8'($urandom);
    apb(1'b1, 12'h0b0, tb);
    sbyte(1'b1, ~b1, got);
    apb(1'b0, 12'h0ac, 8'h00);
    chk(rd, 32'h0);
    sbyte(1'b0, b1, got);
    chk(got, tb);
    sbyte(1'b0, ~b1, got);
    chk(got, b1);
    apb(1'b0, 12'h0ac, 8'h00);
    chk(rd, 32'h0a0);
    apb(1'b0, 12'h0b0, 8'h00);
    chk(rd, {24'h0, ~b1});
    apb(1'b0, 12'h0ac, 8'h00);
    chk(rd, 32'h0);
    print_verdict;
  end
endmodule // tb_top
